// file: dv/fsp_flash_model.sv
// Flash array model answering the sequencer's erase, program and read traffic
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
  input wire logic clk_sys_i,
  input wire fsp_pkg::fsp_flash_cmd_t cmd_i,
  input wire logic [14:0] rd_addr_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem [0:32767];
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'hFFFF;
  end
  always @(posedge clk_sys_i) begin
    if (cmd_i.erase) begin
      for (int w = 0; w < 32; w++) mem[{cmd_i.page, 5'(w)}] <= 16'hFFFF;
    end
    // Programming only clears bits, so a missed erase shows up
    if (cmd_i.wr) mem[{cmd_i.page, cmd_i.word}] <= mem[{cmd_i.page, cmd_i.word}] & cmd_i.data;
  end
  assign rd_data_o = mem[rd_addr_i];
endmodule : fsp_flash_model
`default_nettype wire

// file: dv/fsp_sequencer_bench.sv
// Testbench: sequencer against flash model, random and corner sequences
`timescale 1ns/1ps
`default_nettype none
module fsp_sequencer_bench;
  localparam int OPC = 40;
  logic clk_sys_i, rst_i, ctrl_wr_i, spm_i, eep_i, lpm_i, halt_o, fblk_o, lpm_valid_o;
  logic [7:0] ctrl_data_i, ctl_o, lpm_data_o;
  logic [15:0] ptr_i, data_i, rd_data;
  logic [14:0] rd_addr;
  fsp_pkg::fsp_flash_cmd_t cmd_o;
  logic [15:0] ebuf [32];
  logic [9:0] pg;
  logic [4:0] r;
  int bad_count, cmp_count, seed, n;
  fsp_sequencer #(.OP_CYCLES(OPC)) u_fsp_sequencer (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_data_i(ctrl_data_i), .spm_i(spm_i), .ptr_i(ptr_i),
    .data_word_pair_i(data_i), .eeprom_write_busy_i(eep_i), .lpm_i(lpm_i),
    .flash_rd_data_i(rd_data), .self_prog_control_o(ctl_o), .cpu_halt_o(halt_o),
    .fuse_read_block_o(fblk_o), .flash_cmd_o(cmd_o), .flash_rd_addr_o(rd_addr),
    .lpm_data_o(lpm_data_o), .lpm_valid_o(lpm_valid_o));
  fsp_flash_model u_fsp_flash_model (.clk_sys_i(clk_sys_i), .cmd_i(cmd_o),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  function automatic logic [7:0] exp_byte(input logic [15:0] wd, input bit hi);
    return hi ? wd[15:8] : wd[7:0];
  endfunction : exp_byte
  task automatic clr;
    for (int w = 0; w < 32; w++) ebuf[w] = 16'hFFFF;
  endtask : clr
  task automatic cmd(input logic [7:0] code, input logic [15:0] p, input logic [15:0] d,
                     input bit s);
    @(negedge clk_sys_i);
    ctrl_wr_i = 1'b1;
    ctrl_data_i = code;
    @(negedge clk_sys_i);
    ctrl_wr_i = 1'b0;
    spm_i = s;
    ptr_i = p;
    data_i = d;
    @(negedge clk_sys_i);
    spm_i = 1'b0;
  endtask : cmd
  task automatic load(input logic [4:0] w, input logic [15:0] d);
    cmd(fsp_pkg::CMD_LOAD, {pg, w, 1'b0}, d, 1'b1);
    ebuf[w] = d;
  endtask : load
  task automatic op(input logic [7:0] code, input logic [15:0] p);
    cmd(code, p, 16'($random(seed)), 1'b1);
    n = 0;
    while (halt_o !== 1'b1 && n < 4) begin
      @(negedge clk_sys_i);
      n++;
    end
    n = 0;
    while (halt_o === 1'b1 && n < OPC + 8) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(n, OPC);
  endtask : op
  task automatic chk_page;
    for (int i = 0; i < 64; i++) begin
      @(negedge clk_sys_i);
      lpm_i = 1'b1;
      ptr_i = {pg, 6'(i)};
      @(negedge clk_sys_i);
      lpm_i = 1'b0;
      n = 0;
      while (lpm_valid_o !== 1'b1 && n < 4) begin
        @(negedge clk_sys_i);
        n++;
      end
      chk(lpm_valid_o, 1'b1);
      chk(lpm_data_o, exp_byte(ebuf[i / 2], i[0]));
    end
  endtask : chk_page
  task automatic trial(input int kind);
    pg = 10'($random(seed));
    r = 5'($random(seed));
    for (int w = 0; w < 8; w++) load(5'(w) ^ r, 16'($random(seed)));
    if (kind == 0) op(fsp_pkg::CMD_WRITE, {~pg, 6'h00});
    if (kind == 1) cmd(8'h10, 16'h0000, 16'h0000, 1'b0);
    if (kind == 2) begin
      eep_i = 1'b1;
      cmd(fsp_pkg::CMD_LOAD, {pg, 6'h3E}, 16'h1234, 1'b1);
      chk(ctl_o, 8'h00);
      chk(fblk_o, 1'b1);
      eep_i = 1'b0;
    end
    clr();
    load(r, 16'h5A3C);
    op(fsp_pkg::CMD_ERASE, {pg, 6'h00});
    op(fsp_pkg::CMD_WRITE, {pg, 6'h00});
    chk_page();
  endtask : trial
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    seed = 66;
    bad_count = 0;
    cmp_count = 0;
    {rst_i, ctrl_wr_i, spm_i, eep_i, lpm_i} = 5'h10;
    {ctrl_data_i, ptr_i, data_i} = 40'h00_0000_0000;
    clr();
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(ctl_o, 8'h00);
    chk(halt_o, 1'b0);
    // Full page loaded in scrambled order, then erase with stray low bits
    pg = 10'($random(seed));
    r = 5'($random(seed));
    for (int w = 0; w < 32; w++) load(5'(w) ^ r, 16'($random(seed)));
    op(fsp_pkg::CMD_ERASE, {pg, r, 1'b1});
    op(fsp_pkg::CMD_WRITE, {pg, 6'h00});
    chk_page();
    for (int k = 0; k < 3; k++) trial(k);
    // Armed erase left to expire, late store must do nothing
    cmd(fsp_pkg::CMD_ERASE, 16'h0040, 16'h0000, 1'b0);
    chk(ctl_o, fsp_pkg::CMD_ERASE);
    repeat (3) @(negedge clk_sys_i);
    chk(ctl_o, 8'h00);
    spm_i = 1'b1;
    @(negedge clk_sys_i);
    spm_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk(halt_o, 1'b0);
    give_verdict();
  end
endmodule : fsp_sequencer_bench
`default_nettype wire

// file: inc/fsp_pkg.sv
// Package: constants and types for the flash self-programming sequencer
package fsp_pkg;

  // ****************************************
  // Address pointer layout
  // ****************************************
  localparam int PTR_BITS = 16;
  localparam int WORD_BITS = 5;
  localparam int PAGE_WORDS = 32;
  localparam int WORD_LSB = 1;
  localparam int PAGE_LSB = WORD_LSB + WORD_BITS;
  localparam int PAGE_BITS = PTR_BITS - PAGE_LSB;
  localparam int DATA_BITS = 16;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam int RWW_REENABLE_POS = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int ARM_WINDOW = 4;
  localparam int CLK_PERIOD_PS = 8000;
  localparam longint PROG_TIME_MIN_PS = 64'd3700000000;
  localparam longint PROG_TIME_MAX_PS = 64'd4500000000;
  // Least time rounds up
  localparam int PROG_CYCLES =
    int'((PROG_TIME_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int PROG_CYCLES_MAX = int'(PROG_TIME_MAX_PS / CLK_PERIOD_PS);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_WRITE
  } fsp_state_t;

  typedef struct packed {
    logic erase;
    logic wr;
    logic [PAGE_BITS-1:0] page;
    logic [WORD_BITS-1:0] word;
    logic [DATA_BITS-1:0] data;
  } fsp_flash_cmd_t;

endpackage : fsp_pkg

// file: rtl/fsp_sequencer.sv
// Flash self-programming sequencer: command arming, page buffer, erase/write timing
`timescale 1ns/1ps
`default_nettype none

module fsp_sequencer #(
  parameter int OP_CYCLES = fsp_pkg::PROG_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_data_i,
  input wire logic spm_i,
  input wire logic [fsp_pkg::PTR_BITS-1:0] ptr_i,
  input wire logic [fsp_pkg::DATA_BITS-1:0] data_word_pair_i,
  input wire logic eeprom_write_busy_i,
  input wire logic lpm_i,
  input wire logic [fsp_pkg::DATA_BITS-1:0] flash_rd_data_i,
  output logic [7:0] self_prog_control_o,
  output logic cpu_halt_o,
  output logic fuse_read_block_o,
  output fsp_pkg::fsp_flash_cmd_t flash_cmd_o,
  output logic [fsp_pkg::PTR_BITS-2:0] flash_rd_addr_o,
  output logic [7:0] lpm_data_o,
  output logic lpm_valid_o
);

  localparam int WB = fsp_pkg::WORD_BITS;
  localparam int PB = fsp_pkg::PAGE_BITS;
  localparam int NW = fsp_pkg::PAGE_WORDS;
  localparam int TB = $clog2(OP_CYCLES + 1);

  // ****************************************
  // State
  // ****************************************
  fsp_pkg::fsp_state_t state_reg;
  fsp_pkg::fsp_state_t state_next;
  logic [7:0] cmd_reg;
  logic [2:0] win_reg;
  logic [TB-1:0] timer_reg;
  logic [PB-1:0] page_reg;
  logic [WB:0] stream_reg;
  logic [NW-1:0] valid_reg;
  logic [fsp_pkg::DATA_BITS-1:0] buf_reg [NW];
  logic ee_busy_d_reg;
  fsp_pkg::fsp_flash_cmd_t flash_cmd_reg;
  logic [fsp_pkg::PTR_BITS-2:0] rd_addr_reg;
  logic rd_sel_reg;
  logic rd_pend_reg;
  logic [7:0] lpm_data_reg;
  logic lpm_valid_reg;

  // ****************************************
  // Decode
  // ****************************************
  wire idle_w = (state_reg == fsp_pkg::ST_IDLE);
  // Control writes are locked out while the EEPROM writes
  wire ctrl_take_w = ctrl_wr_i && !eeprom_write_busy_i && idle_w;
  wire armed_w = (cmd_reg != fsp_pkg::CMD_NONE) && (win_reg < 3'(fsp_pkg::ARM_WINDOW));
  wire spm_take_w = spm_i && armed_w && idle_w && !ctrl_wr_i;
  wire do_load_w = spm_take_w && (cmd_reg == fsp_pkg::CMD_LOAD);
  wire do_erase_w = spm_take_w && (cmd_reg == fsp_pkg::CMD_ERASE);
  wire do_write_w = spm_take_w && (cmd_reg == fsp_pkg::CMD_WRITE);
  wire [WB-1:0] word_idx_w = ptr_i[fsp_pkg::PAGE_LSB-1:fsp_pkg::WORD_LSB];
  wire [PB-1:0] page_idx_w = ptr_i[fsp_pkg::PTR_BITS-1:fsp_pkg::PAGE_LSB];
  wire rww_clear_w = ctrl_take_w && ctrl_data_i[fsp_pkg::RWW_REENABLE_POS];
  wire op_done_w = !idle_w && (timer_reg == TB'(OP_CYCLES - 1));
  wire write_done_w = op_done_w && (state_reg == fsp_pkg::ST_WRITE);
  // Loading is in progress once any word sits in the buffer
  wire ee_discard_w = eeprom_write_busy_i && !ee_busy_d_reg && (|valid_reg);
  wire buf_clear_w = write_done_w || rww_clear_w || ee_discard_w;
  wire stream_on_w = (state_reg == fsp_pkg::ST_WRITE) && !stream_reg[WB];
  wire [WB-1:0] stream_idx_w = stream_reg[WB-1:0];

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fsp_pkg::ST_IDLE: begin
        if (do_erase_w) begin
          state_next = fsp_pkg::ST_ERASE;
        end else if (do_write_w) begin
          state_next = fsp_pkg::ST_WRITE;
        end
      end
      fsp_pkg::ST_ERASE,
      fsp_pkg::ST_WRITE: begin
        if (op_done_w) begin
          state_next = fsp_pkg::ST_IDLE;
        end
      end
      default: state_next = fsp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= fsp_pkg::ST_IDLE;
      timer_reg <= '0;
      page_reg <= '0;
      stream_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (idle_w) begin
        timer_reg <= '0;
        stream_reg <= '0;
      end else begin
        timer_reg <= timer_reg + TB'(1);
        if (stream_on_w) begin
          stream_reg <= stream_reg + (WB+1)'(1);
        end
      end
      if (do_erase_w || do_write_w) begin
        page_reg <= page_idx_w;
      end
    end
  end

  // ****************************************
  // Command arming
  // ****************************************
  // Bit 0 reads back until the command runs or the window runs out
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_reg <= fsp_pkg::CTRL_RESET;
      win_reg <= '0;
    end else if (ctrl_take_w) begin
      cmd_reg <= ctrl_data_i;
      win_reg <= '0;
    end else if (spm_take_w || (cmd_reg != fsp_pkg::CMD_NONE &&
                 win_reg == 3'(fsp_pkg::ARM_WINDOW - 1))) begin
      cmd_reg <= fsp_pkg::CMD_NONE;
      win_reg <= '0;
    end else if (cmd_reg != fsp_pkg::CMD_NONE) begin
      win_reg <= win_reg + 3'd1;
    end
  end

  // ****************************************
  // Temporary page buffer
  // ****************************************
  // Erase leaves the buffer alone, so either fill order works
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      valid_reg <= '0;
      ee_busy_d_reg <= 1'b0;
    end else begin
      ee_busy_d_reg <= eeprom_write_busy_i;
      if (buf_clear_w) begin
        valid_reg <= '0;
      end else if (do_load_w) begin
        valid_reg[word_idx_w] <= 1'b1;
      end
    end
  end

  // Words are stored at any index; unloaded words read as erased
  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++) begin : g_buf
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          buf_reg[gi] <= '1;
        end else if (buf_clear_w) begin
          buf_reg[gi] <= '1;
        end else if (do_load_w && word_idx_w == WB'(gi)) begin
          buf_reg[gi] <= data_word_pair_i;
        end
      end
    end
  endgenerate

  // ****************************************
  // Flash macro port
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flash_cmd_reg <= '0;
    end else begin
      flash_cmd_reg.erase <= do_erase_w;
      flash_cmd_reg.wr <= stream_on_w;
      flash_cmd_reg.page <= do_erase_w ? page_idx_w : page_reg;
      flash_cmd_reg.word <= stream_idx_w;
      flash_cmd_reg.data <= buf_reg[stream_idx_w];
    end
  end

  // ****************************************
  // Byte reads of program memory
  // ****************************************
  // One cycle for the macro to answer, one to pick the byte
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_addr_reg <= '0;
      rd_sel_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      lpm_data_reg <= '0;
      lpm_valid_reg <= 1'b0;
    end else begin
      rd_pend_reg <= lpm_i;
      lpm_valid_reg <= rd_pend_reg;
      if (lpm_i) begin
        rd_addr_reg <= ptr_i[fsp_pkg::PTR_BITS-1:1];
        rd_sel_reg <= ptr_i[0];
      end
      if (rd_pend_reg) begin
        lpm_data_reg <= rd_sel_reg ? flash_rd_data_i[15:8] : flash_rd_data_i[7:0];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign self_prog_control_o = cmd_reg;
  assign cpu_halt_o = !idle_w;
  assign fuse_read_block_o = eeprom_write_busy_i;
  assign flash_cmd_o = flash_cmd_reg;
  assign flash_rd_addr_o = rd_addr_reg;
  assign lpm_data_o = lpm_data_reg;
  assign lpm_valid_o = lpm_valid_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Halt span counted apart from the sequencer's own timer
  logic [TB-1:0] halt_cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !cpu_halt_o) begin
      halt_cnt_reg <= '0;
    end else begin
      halt_cnt_reg <= halt_cnt_reg + TB'(1);
    end
  end

  chk_halt_span: assert property ($fell(cpu_halt_o) |-> halt_cnt_reg == TB'(OP_CYCLES))
    else $error("Halt span differs from operation length");

  chk_halt_hold: assert property (do_erase_w |=> cpu_halt_o [*8])
    else $error("CPU not halted after erase start");

  chk_erase_page: assert property (do_erase_w |=> flash_cmd_o.erase &&
    flash_cmd_o.page == $past(page_idx_w))
    else $error("Erase pulse or page wrong");

  chk_load_store: assert property (do_load_w && !buf_clear_w |=>
    valid_reg[$past(word_idx_w)] && buf_reg[$past(word_idx_w)] == $past(data_word_pair_i))
    else $error("Loaded word not stored");

  chk_window_expire: assert property ((ctrl_take_w && ctrl_data_i != 8'h00) ##1
    (!spm_i && !ctrl_wr_i) [*4] |=> cmd_reg == 8'h00)
    else $error("Armed command outlived window");

  chk_ee_block: assert property (ctrl_wr_i && eeprom_write_busy_i && cmd_reg == 8'h00
    |=> cmd_reg == 8'h00)
    else $error("Control write taken during EEPROM write");

  chk_write_clear: assert property (write_done_w |=> valid_reg == '0)
    else $error("Buffer not cleared after write");

  chk_ee_discard: assert property ($rose(eeprom_write_busy_i) && |valid_reg
    |=> valid_reg == '0)
    else $error("Buffer kept across EEPROM write");

  chk_erase_keeps: assert property (state_reg == fsp_pkg::ST_ERASE && !rww_clear_w &&
    !ee_discard_w && !do_load_w |=> valid_reg == $past(valid_reg))
    else $error("Erase disturbed buffer");

  chk_lpm_byte: assert property (lpm_i |-> ##2 lpm_valid_o &&
    lpm_data_o == ($past(rd_sel_reg) ? $past(flash_rd_data_i[15:8])
                                     : $past(flash_rd_data_i[7:0])))
    else $error("Byte read wrong");

  chk_op_length: assert property (op_done_w |-> timer_reg == TB'(OP_CYCLES - 1) ##1
    !cpu_halt_o)
    else $error("Operation length wrong");

endmodule : fsp_sequencer

`default_nettype wire
